// ===== hdl/motor_stop_pkg.sv
// Constants and types for the stop, inhibit and launch logic
package motor_stop_pkg;
  // Clock rate and motion tick
  localparam int CLK_HZ      = 10_000_000;
  localparam int TICK_MS     = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TICKS_PER_S = 1000 / TICK_MS;
  // Register byte offsets
  localparam logic [7:0] OFS_QACT  = 8'h00;
  localparam logic [7:0] OFS_QTRQ  = 8'h04;
  localparam logic [7:0] OFS_QRATE = 8'h08;
  localparam logic [7:0] OFS_CRATE = 8'h0C;
  localparam logic [7:0] OFS_CTIME = 8'h10;
  localparam logic [7:0] OFS_BACT  = 8'h14;
  localparam logic [7:0] OFS_PACT  = 8'h18;
  localparam logic [7:0] OFS_SPEED = 8'h1C;
  localparam logic [7:0] OFS_PDEC  = 8'h20;
  localparam logic [7:0] OFS_PTRQ  = 8'h24;
  localparam logic [7:0] OFS_STAT  = 8'h28;
  localparam logic [7:0] OFS_POS   = 8'h2C;
  localparam logic [7:0] OFS_TIDX  = 8'h30;
  localparam logic [7:0] OFS_TDATA = 8'h34;
  // Reset values
  localparam logic [3:0]  QACT_DEF  = 4'h2;
  localparam logic [13:0] QTRQ_DEF  = 14'h0000;
  localparam logic [29:0] RATE_DEF  = 30'h0000_03E8;
  localparam logic [1:0]  BACT_DEF  = 2'h1;
  localparam logic [3:0]  PACT_DEF  = 4'h1;
  localparam logic [31:0] SPEED_DEF = 32'h0000_0064;
  localparam logic [13:0] PTRQ_DEF  = 14'h2710;
  // Setting limits
  localparam logic [13:0] TRQ_MAX   = 14'h2710;
  localparam logic [29:0] VAL_MAX   = 30'h3B9A_CA00;
  // Stop action codes, four-bit two's complement
  localparam logic [3:0] ACT_TIME  = 4'hD;
  localparam logic [3:0] ACT_CRATE = 4'hE;
  localparam logic [3:0] ACT_IMM   = 4'hF;
  localparam logic [3:0] ACT_PROF  = 4'h1;
  localparam logic [3:0] ACT_QRATE = 4'h2;
  // Inhibit action codes
  localparam logic [1:0] BLK_IMM   = 2'h0;
  localparam logic [1:0] BLK_PROF  = 2'h1;
  localparam logic [1:0] BLK_QUICK = 2'h2;
  localparam logic [1:0] BLK_PLAIN = 2'h3;
  // Discrete input bit order
  localparam int IN_QH    = 0;
  localparam int IN_FWD   = 1;
  localparam int IN_REV   = 2;
  localparam int IN_MAN   = 3;
  localparam int IN_START = 4;
  localparam int IN_SEQ   = 5;
  localparam int N_IN     = 6;
  // Stored entry word layout
  localparam int TBL_DIST_W   = 23;
  localparam int TBL_DIR_BIT  = 23;
  localparam int TBL_NEXT_LSB = 24;
  localparam int TBL_DEPTH    = 256;
  // Status word layout
  localparam int ST_READY   = 0;
  localparam int ST_MOVE    = 1;
  localparam int ST_FWD     = 2;
  localparam int ST_REV     = 3;
  localparam int ST_MAN     = 4;
  localparam int ST_DIR     = 5;
  localparam int ST_CUR_LSB = 8;
  // Motion phases and stop methods
  typedef enum logic [1:0] {PH_IDLE, PH_RUN, PH_STOP} phase_t;
  typedef enum logic [2:0] {
    K_IMM, K_PROF, K_QRATE, K_CRATE, K_TIME
  } kind_t;
endpackage

// ===== hdl/motor_stop_ctrl.sv
// Quick halt, direction inhibit and stored-entry launch logic
`timescale 1ns/10ps
// Operation
// - Quick halt stops motor by chosen method
// - Quick halt discards remaining travel distance
// - Quick action defaults 2; -3 time-based
// - Codes -3,-2,-1,1,2 select stop methods
// - Halt torque 0 keeps profile, else 0.1%
// - Quick rate 1..1e9, default 1000
// - Custom rate 1..1e9, default 1000
// - Custom time 1..1e9 ms, default 1000
// - Ready drops on halt, returns on release
// - Decelerating halt finishes despite early release
// - Immediate halt holds detected demand position
// - Inhibit inputs stop their own direction
// - Blocked direction starts ignored, opposite accepted
// - Inhibit action 0..3, default 1
// - Inhibit inputs raise prohibition information flags
// - Move clears after stop, opposite start sets
// - Decelerating inhibit stop finishes, then clears move
// - Immediate inhibit stop holds detected position
// - Force input selects manual sequencing
// - Start runs selected entry, sets sequence origin
// - Manual sequential launch runs next linked entry
// - Otherwise sequential launch runs selected entry
module motor_stop_ctrl #(
  parameter int TICK_CYC = motor_stop_pkg::TICK_CYCLES
) (
  input  wire logic        CLK_I,
  input  wire logic        SRST_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [31:0] DAT_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic        WE_I,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  input  wire logic        QUICK_HALT_IN_I,
  input  wire logic        FORWARD_INHIBIT_IN_I,
  input  wire logic        REVERSE_INHIBIT_IN_I,
  input  wire logic        MANUAL_SEQUENCE_FORCE_IN_I,
  input  wire logic        START_IN_I,
  input  wire logic        SEQUENTIAL_LAUNCH_IN_I,
  input  wire logic [7:0]  ENTRY_SELECT_INPUTS_I,
  output logic             READY_O,
  output logic             MOVE_O,
  output logic             DIR_O,
  output logic             FWD_PROHIBIT_O,
  output logic             REV_PROHIBIT_O,
  output logic      [13:0] TORQUE_LIMIT_O,
  output logic      [31:0] POSITION_O,
  output logic      [31:0] VELOCITY_O
);
  import motor_stop_pkg::*;

  // Block state except the entry table, registered as one word
  typedef struct packed {
    logic [N_IN-1:0] s1;     // Sync first stage
    logic [N_IN-1:0] s2;     // Sync second stage
    logic [N_IN-1:0] s3;     // Previous level, edges
    logic [7:0]  m1;         // Entry select first stage
    logic [7:0]  m2;         // Entry select second stage
    phase_t      phase;      // Motion phase
    logic        dir;        // High for reverse
    logic        qmode;      // Stop caused by quick halt
    logic [31:0] vel;        // Velocity per tick
    logic [31:0] step;       // Decrement per tick
    logic [31:0] rem;        // Remaining travel
    logic [31:0] pos;        // Demand position
    logic [15:0] tick;       // Tick prescaler
    logic [7:0]  cur;        // Entry now running
    logic        fwd_f;      // Forward prohibition info
    logic        rev_f;      // Reverse prohibition info
    logic        ready;      // Operation ready
    logic [13:0] torque;     // Active torque limit
    logic [3:0]  qact;       // Quick halt action
    logic [13:0] qtrq;       // Quick halt torque
    logic [29:0] qrate;      // Quick stop rate
    logic [29:0] crate;      // Custom stopping rate
    logic [29:0] ctime;      // Custom stopping time
    logic [1:0]  bact;       // Inhibit action
    logic [3:0]  pact;       // Plain stop action
    logic [31:0] speed;      // Running speed
    logic [29:0] pdec;       // Profile accel/decel
    logic [13:0] ptrq;       // Profile torque limit
    logic [7:0]  tidx;       // Table access index
    logic        ack;        // Bus acknowledge
    logic [31:0] rdat;       // Bus read data
  } state_t;

  state_t q;                 // Current state
  state_t d;                 // Next state

  // Stored entries: distance, direction, link
  logic [31:0] table_q [TBL_DEPTH];
  logic        tbl_we;       // Table write strobe
  logic [31:0] tbl_wd;       // Table write word

  // Combinational helpers
  logic        req;          // Bus request seen
  logic        wr;           // Write takes effect
  logic [31:0] rd;           // Read mux result
  logic [31:0] st;           // Status word
  logic        tick_now;     // Motion tick
  logic        man;          // Manual sequencing
  logic        fwd_lvl;      // Forward inhibit level
  logic        rev_lvl;      // Reverse inhibit level
  logic        qh_lvl;       // Quick halt level
  logic        start_rise;   // Start edge
  logic        seq_rise;     // Sequential edge
  logic [7:0]  num;          // Entry to launch
  logic [31:0] ent;          // Entry word
  logic        blocked;      // Entry direction inhibited
  logic        stop_go;      // Stop begins now
  kind_t       kind;         // Method of that stop

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] w,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
      begin
        r[i*8 +: 8] = w[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Clamp to 1..1e9, zero is not allowed
  function automatic logic [29:0] val_clamp(input logic [31:0] v);
    if (v == 32'h0)
    begin
      return 30'h1;
    end
    if (v > {2'b00, VAL_MAX})
    begin
      return VAL_MAX;
    end
    return v[29:0];
  endfunction

  // Clamp torque to 0..10000
  function automatic logic [13:0] trq_clamp(input logic [31:0] v);
    if (v > {18'h0, TRQ_MAX})
    begin
      return TRQ_MAX;
    end
    return v[13:0];
  endfunction

  // Stop code to method; unknown codes act as profile
  function automatic kind_t to_kind(input logic [3:0] c);
    unique case (c)
      ACT_TIME:  return K_TIME;
      ACT_CRATE: return K_CRATE;
      ACT_IMM:   return K_IMM;
      ACT_QRATE: return K_QRATE;
      default:   return K_PROF;
    endcase
  endfunction

  // Rate per second to step per tick, never zero
  function automatic logic [31:0] rate_step(input logic [29:0] r);
    logic [29:0] t;
    t = r / 30'(TICKS_PER_S);
    return (t == 30'h0) ? 32'h1 : {2'b00, t};
  endfunction

  // Move demand position by amount in direction
  function automatic logic [31:0] advance(input logic [31:0] p,
                                          input logic        rv,
                                          input logic [31:0] a);
    return rv ? p - a : p + a;
  endfunction

  // Table write port and storage
  always_ff @(posedge CLK_I)
  begin
    if (tbl_we)
    begin
      table_q[q.tidx] <= tbl_wd;
    end
  end

  // Next-state logic for bus, inputs and motion
  always_comb
  begin
    d          = q;
    req        = CYC_I & STB_I;
    wr         = req & WE_I & q.ack;
    rd         = 32'h0;
    st         = 32'h0;
    tbl_we     = 1'b0;
    tbl_wd     = merge(table_q[q.tidx], DAT_I, SEL_I);
    stop_go    = 1'b0;
    kind       = K_PROF;
    d.s1 = {SEQUENTIAL_LAUNCH_IN_I, START_IN_I,
            MANUAL_SEQUENCE_FORCE_IN_I, REVERSE_INHIBIT_IN_I,
            FORWARD_INHIBIT_IN_I, QUICK_HALT_IN_I};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.m1 = ENTRY_SELECT_INPUTS_I;
    d.m2 = q.m1;
    qh_lvl     = q.s2[IN_QH];
    fwd_lvl    = q.s2[IN_FWD];
    rev_lvl    = q.s2[IN_REV];
    start_rise = q.s2[IN_START] & ~q.s3[IN_START];
    seq_rise   = q.s2[IN_SEQ] & ~q.s3[IN_SEQ];
    man = q.s2[IN_MAN];

    // Status word assembly
    st[ST_READY] = q.ready;
    st[ST_MOVE]  = (q.phase != PH_IDLE);
    st[ST_FWD]   = q.fwd_f;
    st[ST_REV]   = q.rev_f;
    st[ST_MAN]   = man;
    st[ST_DIR]   = q.dir;
    st[ST_CUR_LSB +: 8] = q.cur;

    // Read mux; unmapped offsets read zero
    case (ADR_I)
      OFS_QACT:  rd = {28'h0, q.qact};
      OFS_QTRQ:  rd = {18'h0, q.qtrq};
      OFS_QRATE: rd = {2'b00, q.qrate};
      OFS_CRATE: rd = {2'b00, q.crate};
      OFS_CTIME: rd = {2'b00, q.ctime};
      OFS_BACT:  rd = {30'h0, q.bact};
      OFS_PACT:  rd = {28'h0, q.pact};
      OFS_SPEED: rd = q.speed;
      OFS_PDEC:  rd = {2'b00, q.pdec};
      OFS_PTRQ:  rd = {18'h0, q.ptrq};
      OFS_STAT:  rd = st;
      OFS_POS:   rd = q.pos;
      OFS_TIDX:  rd = {24'h0, q.tidx};
      OFS_TDATA: rd = table_q[q.tidx];
      default:   rd = 32'h0;
    endcase

    // One wait state, ack drops the cycle after
    d.ack = req & ~q.ack;
    if (req & ~q.ack)
    begin
      d.rdat = rd;
    end

    // Register writes at the edge that sees ack
    if (wr)
    begin
      case (ADR_I)
        OFS_QACT:  d.qact = 4'(merge({28'h0, q.qact}, DAT_I, SEL_I));
        OFS_QTRQ:  d.qtrq = trq_clamp(
                     merge({18'h0, q.qtrq}, DAT_I, SEL_I));
        OFS_QRATE: d.qrate = val_clamp(
                     merge({2'b00, q.qrate}, DAT_I, SEL_I));
        OFS_CRATE: d.crate = val_clamp(
                     merge({2'b00, q.crate}, DAT_I, SEL_I));
        OFS_CTIME: d.ctime = val_clamp(
                     merge({2'b00, q.ctime}, DAT_I, SEL_I));
        OFS_BACT:  d.bact = 2'(merge({30'h0, q.bact}, DAT_I, SEL_I));
        OFS_PACT:  d.pact = 4'(merge({28'h0, q.pact}, DAT_I, SEL_I));
        OFS_SPEED: d.speed = merge(q.speed, DAT_I, SEL_I);
        OFS_PDEC:  d.pdec = val_clamp(
                     merge({2'b00, q.pdec}, DAT_I, SEL_I));
        OFS_PTRQ:  d.ptrq = trq_clamp(
                     merge({18'h0, q.ptrq}, DAT_I, SEL_I));
        OFS_TIDX:  d.tidx = 8'(merge({24'h0, q.tidx}, DAT_I, SEL_I));
        OFS_TDATA: tbl_we = 1'b1;
        default:   ;
      endcase
    end

    d.fwd_f = (q.fwd_f & ~(wr & (ADR_I == OFS_STAT) &
               DAT_I[ST_FWD])) | (fwd_lvl & ~q.s3[IN_FWD]);
    d.rev_f = (q.rev_f & ~(wr & (ADR_I == OFS_STAT) &
               DAT_I[ST_REV])) | (rev_lvl & ~q.s3[IN_REV]);

    d.ready = ~qh_lvl;

    // Motion tick prescaler
    tick_now = (q.tick == 16'(TICK_CYC - 1));
    d.tick   = tick_now ? 16'h0 : q.tick + 16'h1;

    num = q.m2;
    // next linked entry in manual mode
    if (!start_rise && man)
    begin
      num = table_q[q.cur][TBL_NEXT_LSB +: 8];
    end
    ent     = table_q[num];
    blocked = ent[TBL_DIR_BIT] ? rev_lvl : fwd_lvl;

    unique case (q.phase)
      PH_IDLE:
      begin
        if ((start_rise | seq_rise) & ~qh_lvl & ~blocked)
        begin
          d.phase = PH_RUN;
          d.cur   = num;
          d.dir   = ent[TBL_DIR_BIT];
          d.rem   = {9'h0, ent[TBL_DIST_W-1:0]};
          d.vel   = 32'h0;
        end
      end
      PH_RUN:
      begin
        if (qh_lvl)
        begin
          stop_go = 1'b1;
          kind    = to_kind(q.qact);
          d.qmode = 1'b1;
        end
        else if (q.dir ? rev_lvl : fwd_lvl)
        begin
          stop_go = 1'b1;
          unique case (q.bact)
            BLK_IMM:   kind = K_IMM;
            BLK_PROF:  kind = K_PROF;
            BLK_QUICK: kind = to_kind(q.qact);
            BLK_PLAIN: kind = to_kind(q.pact);
          endcase
        end
        else if (tick_now)
        begin
          // Ramp to running speed, then travel
          if (q.vel < q.speed)
          begin
            d.vel = (q.speed - q.vel > rate_step(q.pdec)) ?
                    q.vel + rate_step(q.pdec) : q.speed;
          end
          if (q.rem <= q.vel)
          begin
            // Target reached this tick
            d.pos   = advance(q.pos, q.dir, q.rem);
            d.rem   = 32'h0;
            d.vel   = 32'h0;
            d.phase = PH_IDLE;
          end
          else
          begin
            d.pos = advance(q.pos, q.dir, q.vel);
            d.rem = q.rem - q.vel;
          end
        end
      end
      PH_STOP:
      begin
        if (tick_now)
        begin
          if (q.vel <= q.step)
          begin
            d.pos   = advance(q.pos, q.dir, q.vel);
            d.vel   = 32'h0;
            d.phase = PH_IDLE;
            d.qmode = 1'b0;
          end
          else
          begin
            d.vel = q.vel - q.step;
            d.pos = advance(q.pos, q.dir, q.vel - q.step);
          end
        end
      end
    endcase

    if (stop_go)
    begin
      d.rem = 32'h0;
      unique case (kind)
        K_IMM:
        begin
          d.vel   = 32'h0;
          d.pos   = q.pos;
          d.phase = PH_IDLE;
          d.qmode = 1'b0;
        end
        K_PROF:  d.step = rate_step(q.pdec);
        K_QRATE: d.step = rate_step(q.qrate);
        K_CRATE: d.step = rate_step(q.crate);
        K_TIME:  d.step = 32'((33'(q.vel) + 33'(q.ctime) -
                              33'h1) / 33'(q.ctime));
      endcase
      if (kind != K_IMM)
      begin
        d.phase = PH_STOP;
      end
    end

    d.torque = (d.qmode && q.qtrq != 14'h0) ? q.qtrq : q.ptrq;

    // Synchronous reset values
    if (SRST_I)
    begin
      d       = '0;
      d.phase = PH_IDLE;
      d.qact  = QACT_DEF;
      d.qtrq  = QTRQ_DEF;
      d.qrate = RATE_DEF;
      d.crate = RATE_DEF;
      d.ctime = RATE_DEF;
      d.bact  = BACT_DEF;
      d.pact  = PACT_DEF;
      d.speed = SPEED_DEF;
      d.pdec  = RATE_DEF;
      d.ptrq  = PTRQ_DEF;
      d.torque = PTRQ_DEF;
      tbl_we  = 1'b0;
    end
  end

  // State register
  always_ff @(posedge CLK_I)
  begin
    q <= d;
  end

  // Outputs straight from state
  assign DAT_O          = q.rdat;
  assign ACK_O          = q.ack;
  assign READY_O        = q.ready;
  assign MOVE_O         = (q.phase != PH_IDLE);
  assign DIR_O          = q.dir;
  assign FWD_PROHIBIT_O = q.fwd_f;
  assign REV_PROHIBIT_O = q.rev_f;
  assign TORQUE_LIMIT_O = q.torque;
  assign POSITION_O     = q.pos;
  assign VELOCITY_O     = q.vel;
endmodule

// ===== bench/motor_stop_ctrl_asserts.sv
// Concurrent checks on the halt, inhibit and launch ports
`timescale 1ns/10ps
module motor_stop_ctrl_asserts (
  input wire logic        CLK_I,
  input wire logic        SRST_I,
  input wire logic [7:0]  ADR_I,
  input wire logic        WE_I,
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic [31:0] DAT_O,
  input wire logic        ACK_O,
  input wire logic        QUICK_HALT_IN_I,
  input wire logic        FORWARD_INHIBIT_IN_I,
  input wire logic        REVERSE_INHIBIT_IN_I,
  input wire logic        START_IN_I,
  input wire logic        READY_O,
  input wire logic        MOVE_O,
  input wire logic        DIR_O,
  input wire logic        FWD_PROHIBIT_O,
  input wire logic        REV_PROHIBIT_O,
  input wire logic [31:0] POSITION_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (SRST_I);
  // Inhibit held long enough to pass the synchroniser
  sequence fwd_held;
    FORWARD_INHIBIT_IN_I [*4];
  endsequence
  sequence rev_held;
    REVERSE_INHIBIT_IN_I [*4];
  endsequence
  // A move begins
  sequence launch;
    $rose(MOVE_O);
  endsequence
  chk_ack_once: assert property (ACK_O |=> !ACK_O)
    else $error("ack held longer than one cycle");
  chk_ack_late: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("ack missing one cycle after request");
  chk_unmapped_zero: assert property (
    ACK_O && !WE_I && ADR_I >= 8'h38 |-> DAT_O == 32'h0)
    else $error("unmapped read not zero");
  chk_ready_low: assert property (
    QUICK_HALT_IN_I [*4] |-> !READY_O)
    else $error("ready high during quick halt");
  chk_ready_back: assert property (
    (!QUICK_HALT_IN_I && !SRST_I) [*4] |-> READY_O)
    else $error("ready low without quick halt");
  chk_fwd_flag: assert property (
    $rose(FORWARD_INHIBIT_IN_I) |-> ##[1:4] FWD_PROHIBIT_O)
    else $error("forward flag not raised");
  chk_rev_flag: assert property (
    $rose(REVERSE_INHIBIT_IN_I) |-> ##[1:4] REV_PROHIBIT_O)
    else $error("reverse flag not raised");
  chk_fwd_block: assert property (fwd_held ##0 launch |-> DIR_O)
    else $error("forward move started while inhibited");
  chk_rev_block: assert property (rev_held ##0 launch |-> !DIR_O)
    else $error("reverse move started while inhibited");
  chk_idle_still: assert property (
    !MOVE_O && !$past(MOVE_O) |-> $stable(POSITION_O))
    else $error("position moved while idle");
  chk_launch_time: assert property (
    $rose(START_IN_I) && !MOVE_O && READY_O && !FORWARD_INHIBIT_IN_I
    && !REVERSE_INHIBIT_IN_I |-> ##[2:4] MOVE_O)
    else $error("start did not launch a move");
endmodule
bind motor_stop_ctrl motor_stop_ctrl_asserts u_chk (
  .CLK_I, .SRST_I, .ADR_I, .WE_I, .CYC_I, .STB_I, .DAT_O, .ACK_O,
  .QUICK_HALT_IN_I, .FORWARD_INHIBIT_IN_I, .REVERSE_INHIBIT_IN_I,
  .START_IN_I, .READY_O, .MOVE_O, .DIR_O, .FWD_PROHIBIT_O,
  .REV_PROHIBIT_O, .POSITION_O
);

// ===== bench/host_model.sv
// Host controller model driving the discrete control pins
`timescale 1ns/10ps
module host_model (
  input  wire logic  clk_i,
  output logic       halt_o,
  output logic       fwd_o,
  output logic       rev_o,
  output logic       man_o,
  output logic       start_o,
  output logic       seq_o,
  output logic [7:0] sel_o
);
  // All pins quiet from time zero
  initial
  begin
    {halt_o, fwd_o, rev_o, man_o, start_o, seq_o} = 6'h00;
    sel_o = 8'h00;
  end
  // Level pins change just after an edge
  task automatic levels(input logic h, f, r, m);
    @(posedge clk_i);
    {halt_o, fwd_o, rev_o, man_o} <= {h, f, r, m};
  endtask
  task automatic pick(input logic [7:0] n);
    @(posedge clk_i);
    sel_o <= n;
  endtask
  // two cycles high and low, so the edge is never missed
  task automatic pulse(input logic sq);
    @(posedge clk_i);
    if (sq)
      seq_o <= 1'b1;
    else
      start_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    {start_o, seq_o} <= 2'h0;
    repeat (2) @(posedge clk_i);
  endtask
endmodule

// ===== bench/motor_stop_ctrl_tb.sv
// Self-checking bench for the halt, inhibit and launch logic
`timescale 1ns/10ps
module motor_stop_ctrl_tb;
  import motor_stop_pkg::*;
  // Nets named as the ports so the instance stays short
  logic        CLK_I = 1'b0;
  logic        SRST_I = 1'b1;
  logic [7:0]  ADR_I = 8'h00;
  logic [31:0] DAT_I = 32'h0;
  logic [3:0]  SEL_I = 4'hF;
  logic        WE_I = 1'b0;
  logic        CYC_I = 1'b0;
  logic        STB_I = 1'b0;
  logic [31:0] DAT_O, POSITION_O, VELOCITY_O, r, p0;
  logic [13:0] TORQUE_LIMIT_O;
  logic        ACK_O, READY_O, MOVE_O, DIR_O;
  logic        FWD_PROHIBIT_O, REV_PROHIBIT_O;
  logic        QUICK_HALT_IN_I, FORWARD_INHIBIT_IN_I, REVERSE_INHIBIT_IN_I;
  logic        MANUAL_SEQUENCE_FORCE_IN_I, START_IN_I;
  logic        SEQUENTIAL_LAUNCH_IN_I;
  logic [7:0]  ENTRY_SELECT_INPUTS_I;
  int          fail_count = 0;
  int          compares = 0;
  int          cyc_n = 0;
  logic [7:0]  ofs[6] = '{OFS_QACT, OFS_QTRQ, OFS_QRATE, OFS_CRATE,
                          OFS_CTIME, OFS_BACT};
  logic [31:0] dfl[6] = '{32'h2, 32'h0, 32'h3E8, 32'h3E8, 32'h3E8, 32'h1};
  logic [3:0]  codes[4] = '{ACT_TIME, ACT_CRATE, ACT_PROF, ACT_QRATE};
  always #50 CLK_I = ~CLK_I;
  // Short motion tick keeps moves to tens of cycles
  motor_stop_ctrl #(.TICK_CYC(4)) u_dut (
    .CLK_I, .SRST_I, .ADR_I, .DAT_I, .SEL_I, .WE_I, .CYC_I, .STB_I,
    .DAT_O, .ACK_O, .QUICK_HALT_IN_I, .FORWARD_INHIBIT_IN_I,
    .REVERSE_INHIBIT_IN_I, .MANUAL_SEQUENCE_FORCE_IN_I, .START_IN_I,
    .SEQUENTIAL_LAUNCH_IN_I, .ENTRY_SELECT_INPUTS_I, .READY_O, .MOVE_O,
    .DIR_O, .FWD_PROHIBIT_O, .REV_PROHIBIT_O, .TORQUE_LIMIT_O,
    .POSITION_O, .VELOCITY_O
  );
  host_model u_host (
    .clk_i   (CLK_I),
    .halt_o  (QUICK_HALT_IN_I),
    .fwd_o   (FORWARD_INHIBIT_IN_I),
    .rev_o   (REVERSE_INHIBIT_IN_I),
    .man_o   (MANUAL_SEQUENCE_FORCE_IN_I),
    .start_o (START_IN_I),
    .seq_o   (SEQUENTIAL_LAUNCH_IN_I),
    .sel_o   (ENTRY_SELECT_INPUTS_I)
  );
  task automatic check(string nm, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Classic single cycle, held until ack is sampled
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK_I);
    ADR_I <= a;
    DAT_I <= d;
    WE_I <= w;
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    @(posedge CLK_I);
    while (ACK_O !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge CLK_I);
    end
    r = DAT_O;
    check("ack", ACK_O, 1'b1);
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    WE_I <= 1'b0;
  endtask
  // Bounded wait for the move output level
  task automatic wait_mv(logic v);
    int n;
    n = 0;
    while (MOVE_O !== v && n < 400)
    begin
      n++;
      @(posedge CLK_I);
    end
    // A wait that runs out counts as a mismatch
    check("move level", MOVE_O, v);
  endtask
  task automatic run(logic [7:0] e, logic s);
    u_host.pick(e);
    u_host.pulse(s);
  endtask
  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge CLK_I)
  begin
    cyc_n++;
    if (cyc_n == 8000)
    begin
      fail_count++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (3) @(posedge CLK_I);
    SRST_I <= 1'b0;
    foreach (ofs[i])
    begin
      wb(1'b0, ofs[i], 32'h0);
      check("default", r, dfl[i]);
    end
    wb(1'b0, 8'h38, 32'h0);
    check("unmapped", r, 32'h0);
    wb(1'b1, OFS_QTRQ, 32'hFFFF_FFFF);
    wb(1'b0, OFS_QTRQ, 32'h0);
    check("torque clamp", r, 32'h2710);
    wb(1'b1, OFS_QTRQ, 32'h1F4);
    // Entry 5: forward 40, linked to 6; entry 6: reverse 20
    wb(1'b1, OFS_TIDX, 32'h5);
    wb(1'b1, OFS_TDATA, 32'h0600_0028);
    wb(1'b1, OFS_TIDX, 32'h6);
    wb(1'b1, OFS_TDATA, 32'h0080_0014);
    $display("test registers done");
    run(8'h05, 1'b0);
    check("dir", DIR_O, 1'b0);
    wait_mv(1'b0);
    check("position", POSITION_O, 32'd40);
    u_host.levels(1'b0, 1'b0, 1'b0, 1'b1);
    repeat (4) @(posedge CLK_I);
    wb(1'b0, OFS_STAT, 32'h0);
    check("manual", r[ST_MAN], 1'b1);
    run(8'h05, 1'b1);
    check("dir", DIR_O, 1'b1);
    wait_mv(1'b0);
    check("position", POSITION_O, 32'd20);
    u_host.levels(1'b0, 1'b0, 1'b0, 1'b0);
    run(8'h05, 1'b1);
    wait_mv(1'b0);
    check("position", POSITION_O, 32'd60);
    $display("test launch done");
    u_host.levels(1'b0, 1'b0, 1'b1, 1'b0);
    run(8'h06, 1'b0);
    check("rev flag", REV_PROHIBIT_O, 1'b1);
    check("blocked", MOVE_O, 1'b0);
    run(8'h05, 1'b0);
    wait_mv(1'b0);
    u_host.levels(1'b0, 1'b1, 1'b0, 1'b0);
    run(8'h05, 1'b0);
    check("fwd flag", FWD_PROHIBIT_O, 1'b1);
    check("blocked", MOVE_O, 1'b0);
    run(8'h06, 1'b0);
    check("opposite", MOVE_O, 1'b1);
    wait_mv(1'b0);
    check("position", POSITION_O, 32'd80);
    u_host.levels(1'b0, 1'b0, 1'b0, 1'b0);
    // Inhibit pulse shorter than the deceleration
    run(8'h05, 1'b0);
    repeat (16) @(posedge CLK_I);
    u_host.levels(1'b0, 1'b1, 1'b0, 1'b0);
    repeat (3) @(posedge CLK_I);
    u_host.levels(1'b0, 1'b0, 1'b0, 1'b0);
    // Let the release pass the synchroniser first
    repeat (4) @(posedge CLK_I);
    check("still stopping", MOVE_O, 1'b1);
    wait_mv(1'b0);
    check("stopped short", POSITION_O < 32'd120, 1'b1);
    // Immediate inhibit stop
    wb(1'b1, OFS_BACT, {30'h0, BLK_IMM});
    run(8'h05, 1'b0);
    repeat (8) @(posedge CLK_I);
    u_host.levels(1'b0, 1'b1, 1'b0, 1'b0);
    repeat (4) @(posedge CLK_I);
    check("inhibit halt", MOVE_O, 1'b0);
    check("inhibit velocity", VELOCITY_O, 32'h0);
    u_host.levels(1'b0, 1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge CLK_I);
    $display("test inhibit done");
    wb(1'b1, OFS_QACT, {28'h0, ACT_IMM});
    run(8'h05, 1'b0);
    repeat (4) @(posedge CLK_I);
    u_host.levels(1'b1, 1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge CLK_I);
    check("halted", MOVE_O, 1'b0);
    check("velocity", VELOCITY_O, 32'h0);
    check("ready", READY_O, 1'b0);
    u_host.levels(1'b0, 1'b0, 1'b0, 1'b0);
    repeat (5) @(posedge CLK_I);
    check("ready", READY_O, 1'b1);
    check("no resume", MOVE_O, 1'b0);
    p0 = POSITION_O;
    run(8'h05, 1'b0);
    wait_mv(1'b0);
    check("full travel", POSITION_O - p0, 32'd40);
    $display("test immediate halt done");
    foreach (codes[i])
    begin
      wb(1'b1, OFS_QACT, {28'h0, codes[i]});
      run(8'h05, 1'b0);
      repeat (12) @(posedge CLK_I);
      u_host.levels(1'b1, 1'b0, 1'b0, 1'b0);
      repeat (4) @(posedge CLK_I);
      check("halt torque", TORQUE_LIMIT_O, 14'd500);
      u_host.levels(1'b0, 1'b0, 1'b0, 1'b0);
      // Release must reach the logic before the check
      repeat (4) @(posedge CLK_I);
      check("decelerating", MOVE_O, 1'b1);
      wait_mv(1'b0);
      check("ready", READY_O, 1'b1);
      check("profile torque", TORQUE_LIMIT_O, 32'h2710);
    end
    $display("test decelerating halt done");
    give_verdict();
  end
endmodule
